// ===== hdl/dms_consts.svh
// Register indices, field positions and reset values of the drive monitor register bank.
`ifndef DMS_CONSTS_SVH
`define DMS_CONSTS_SVH

// Word indices; the byte address of each register is four times its index.
`define DMS_IDX_STATUS      8'h10
`define DMS_IDX_OPERATOR    8'h11
`define DMS_IDX_ERR_NUM     8'h12
`define DMS_IDX_UNUSED      8'h13
`define DMS_IDX_FAULT1      8'h14
`define DMS_IDX_FAULT2      8'h15
`define DMS_IDX_FAULT3      8'h16
`define DMS_IDX_HWFAULT1    8'h17
`define DMS_IDX_HWFAULT2    8'h18
`define DMS_IDX_IRQ_STATUS  8'h20
`define DMS_IDX_IRQ_MASK    8'h21

// Address bits that hold the word index.
`define DMS_IDX_LSB         2
`define DMS_IDX_MSB         9

// Operator status field positions.
`define DMS_OPER_PANEL_LSB  3
`define DMS_OPER_PANEL_MSB  4

// Interrupt status bit positions; one event bit per fault word and one for a new setting alarm.
`define DMS_IRQ_FAULT1      0
`define DMS_IRQ_FAULT2      1
`define DMS_IRQ_FAULT3      2
`define DMS_IRQ_HWFAULT1    3
`define DMS_IRQ_HWFAULT2    4
`define DMS_IRQ_SETERR      5
`define DMS_IRQ_BITS        6

// Reset values.
`define DMS_IRQ_STATUS_RST  6'h00
`define DMS_IRQ_MASK_RST    6'h00
`define DMS_WORD_RST        16'h0000

`endif

// ===== hdl/dms_monitor_regs.sv
// Drive monitor register bank behind an AXI4-Lite slave, with fault event interrupt.
//
// Contract
// - Monitor registers ignore every host write.
// - Operator bits 4:3 report attached panel type.
// - Operator bits 0-2 flags; next word error number.
// - Fault word 1: fuse, undervoltages, bit 4 zero.
// - Fault word 1: earth, overcurrent, high voltage.
// - Fault word 1: heatsink, motor and drive overload.
// - Fault word 1: overtorque pair, brake faults.
// - Fault word 2: external inputs S3-S7, thermistor.
// - Fault word 2: overspeed through output phase open.
// - Fault word 2: motor hot, keypad, flag E.
// - Fault word 3: serial and option links.
// - Fault word 3: control through PID feedback loss.
// - Fault word 3: undertorque pair, slip brake overload.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dms_consts.svh"

module dms_monitor_regs #(
   parameter int AW = 12
) (
   // Clock and reset.
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_n_i,
   // AXI4-Lite write address and data.
   input  wire logic [AW-1:0]        s_axi_awaddr_i,
   input  wire logic [2:0]           s_axi_awprot_i,
   input  wire logic                 s_axi_awvalid_i,
   output logic                      s_axi_awready_o,
   input  wire logic [31:0]          s_axi_wdata_i,
   input  wire logic [3:0]           s_axi_wstrb_i,
   input  wire logic                 s_axi_wvalid_i,
   output logic                      s_axi_wready_o,
   // AXI4-Lite write response.
   output dms_pkg::dms_resp_t        s_axi_bresp_o,
   output logic                      s_axi_bvalid_o,
   input  wire logic                 s_axi_bready_i,
   // AXI4-Lite read.
   input  wire logic [AW-1:0]        s_axi_araddr_i,
   input  wire logic [2:0]           s_axi_arprot_i,
   input  wire logic                 s_axi_arvalid_i,
   output logic                      s_axi_arready_o,
   output logic [31:0]               s_axi_rdata_o,
   output dms_pkg::dms_resp_t        s_axi_rresp_o,
   output logic                      s_axi_rvalid_o,
   input  wire logic                 s_axi_rready_i,
   // Drive run status.
   input  wire logic [7:0]           drive_state_i,
   input  wire logic                 comm_reference_source_flag_i,
   input  wire logic                 comm_run_source_flag_i,
   // Operator panel status.
   input  wire logic                 parameter_setting_error_i,
   input  wire logic                 fault_active_i,
   input  wire logic                 prog_mode_i,
   input  wire logic [1:0]           panel_type_i,
   input  wire logic [15:0]          setting_error_num_i,
   // First fault word sources.
   input  wire logic                 dc_link_fuse_blown_i,
   input  wire logic [2:0]           undervoltage_fault_i,
   input  wire logic                 earth_leak_fault_i,
   input  wire logic                 overcurrent_fault_i,
   input  wire logic                 dc_link_high_voltage_i,
   input  wire logic                 heatsink_hot_prewarn_i,
   input  wire logic                 heatsink_hot_trip_i,
   input  wire logic                 motor_overload_i,
   input  wire logic                 drive_overload_i,
   input  wire logic [1:0]           overtorque_detect_i,
   input  wire logic                 brake_transistor_fault_i,
   input  wire logic                 brake_resistor_hot_i,
   // Second fault word sources.
   input  wire logic [4:0]           ext_fault_input_i,
   input  wire logic                 ext_fault_thermistor_input_i,
   input  wire logic                 overspeed_trip_i,
   input  wire logic                 speed_mismatch_trip_i,
   input  wire logic                 encoder_disconnect_i,
   input  wire logic                 input_phase_loss_i,
   input  wire logic                 output_phase_open_i,
   input  wire logic                 motor_hot_prewarn_i,
   input  wire logic                 keypad_disconnect_i,
   input  wire logic                 bit_e_fault_flag_i,
   input  wire logic                 motor_hot_trip_i,
   // Third fault word sources.
   input  wire logic                 serial_link_fault_i,
   input  wire logic                 option_board_link_fault_i,
   input  wire logic                 control_fault_i,
   input  wire logic                 zero_servo_fault_i,
   input  wire logic                 option_card_ext_fault_i,
   input  wire logic                 pid_feedback_loss_i,
   input  wire logic [1:0]           undertorque_detect_i,
   input  wire logic                 slip_brake_overload_i,
   // Hardware fault codes: low is 02,03,05,06 and high is 20..23.
   input  wire logic [3:0]           hw_fault_low_i,
   input  wire logic [3:0]           hw_fault_high_i,
   // Interrupt.
   output logic                      irq_o
);
   import dms_pkg::*;

   // The index field must fit and leave at least one bit above it for decode.
   // A bad width stops elaboration instead of building a bank whose words alias.
   if (AW < 11 || AW > 32) begin : g_aw_check
      $error("dms_monitor_regs: AW must lie between 11 and 32");
   end

   // Index of an address, and whether the bits above the index are clear.
   function automatic logic [7:0] dms_index(input logic [AW-1:0] addr);
      return addr[`DMS_IDX_MSB:`DMS_IDX_LSB];
   endfunction : dms_index

   function automatic logic dms_high_clear(input logic [AW-1:0] addr);
      return (addr >> (`DMS_IDX_MSB + 1)) == '0;
   endfunction : dms_high_clear

   // Reset release through two flip-flops.
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // Monitor words assembled from the drive logic; unused bits tie to zero.
   dms_word_t status_word;
   dms_word_t oper_word;
   dms_word_t fault_word [5];
   dms_word_t mon_words [9];
   assign status_word = {comm_run_source_flag_i, comm_reference_source_flag_i,
                         6'h00, drive_state_i};
   assign oper_word   = {11'h000, panel_type_i, prog_mode_i, fault_active_i,
                         parameter_setting_error_i};
   assign fault_word[0] = {brake_resistor_hot_i, brake_transistor_fault_i, overtorque_detect_i,
                           drive_overload_i, motor_overload_i, heatsink_hot_trip_i,
                           heatsink_hot_prewarn_i, dc_link_high_voltage_i, overcurrent_fault_i,
                           earth_leak_fault_i, 1'b0, undervoltage_fault_i,
                           dc_link_fuse_blown_i};
   assign fault_word[1] = {motor_hot_trip_i, bit_e_fault_flag_i, keypad_disconnect_i,
                           motor_hot_prewarn_i, output_phase_open_i, input_phase_loss_i,
                           encoder_disconnect_i, speed_mismatch_trip_i, overspeed_trip_i,
                           1'b0, ext_fault_thermistor_input_i, ext_fault_input_i};
   assign fault_word[2] = {5'h00, slip_brake_overload_i, undertorque_detect_i,
                           pid_feedback_loss_i, option_card_ext_fault_i, zero_servo_fault_i,
                           control_fault_i, 2'b00, option_board_link_fault_i,
                           serial_link_fault_i};
   assign fault_word[3] = {9'h000, hw_fault_low_i[3:2], 1'b0, hw_fault_low_i[1:0], 2'b00};
   assign fault_word[4] = {12'h000, hw_fault_high_i};
   assign mon_words[0] = status_word;
   assign mon_words[1] = oper_word;
   assign mon_words[2] = setting_error_num_i;
   assign mon_words[3] = `DMS_WORD_RST;
   assign mon_words[4] = fault_word[0];
   assign mon_words[5] = fault_word[1];
   assign mon_words[6] = fault_word[2];
   assign mon_words[7] = fault_word[3];
   assign mon_words[8] = fault_word[4];

   // Event detection: a fault bit that turns on since the last cycle raises its word's event.
   logic [`DMS_IRQ_BITS-1:0] irq_set;
   dms_word_t                fault_prev_reg [5];
   logic                     seterr_prev_reg;
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_fault_edge
         always_ff @(posedge sys_clk_i or negedge rst_n) begin
            if (!rst_n) begin
               fault_prev_reg[gi] <= `DMS_WORD_RST;
            end else begin
               fault_prev_reg[gi] <= fault_word[gi];
            end
         end
         assign irq_set[gi] = |(fault_word[gi] & ~fault_prev_reg[gi]);
      end
   endgenerate

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         seterr_prev_reg <= 1'b0;
      end else begin
         seterr_prev_reg <= parameter_setting_error_i;
      end
   end
   assign irq_set[`DMS_IRQ_SETERR] = parameter_setting_error_i & ~seterr_prev_reg;

   // Write channel: address and data are taken independently, then the pair is executed.
   logic            aw_held_reg;
   logic            w_held_reg;
   logic [AW-1:0]   awaddr_reg;
   logic [31:0]     wdata_reg;
   logic [3:0]      wstrb_reg;
   logic            aw_hs;
   logic            w_hs;
   logic            wr_fire;
   logic            aw_held_next;
   logic            w_held_next;
   logic            bvalid_next;
   logic [7:0]      wr_idx;
   logic            wr_mapped;
   logic            wr_mask_hit;
   assign aw_hs        = s_axi_awvalid_i & s_axi_awready_o;
   assign w_hs         = s_axi_wvalid_i & s_axi_wready_o;
   assign wr_fire      = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
   assign aw_held_next = (aw_held_reg | aw_hs) & ~wr_fire;
   assign w_held_next  = (w_held_reg | w_hs) & ~wr_fire;
   assign bvalid_next  = wr_fire | (s_axi_bvalid_o & ~s_axi_bready_i);
   assign wr_idx       = dms_index(awaddr_reg);
   // Only the interrupt mask register takes data; monitor words and the interrupt status answer OKAY and stay as they are.
   assign wr_mapped    = dms_high_clear(awaddr_reg) &
                         (((wr_idx >= `DMS_IDX_STATUS) & (wr_idx <= `DMS_IDX_HWFAULT2)) |
                          (wr_idx == `DMS_IDX_IRQ_STATUS) | (wr_idx == `DMS_IDX_IRQ_MASK));
   assign wr_mask_hit  = wr_fire & dms_high_clear(awaddr_reg) &
                         (wr_idx == `DMS_IDX_IRQ_MASK) & wstrb_reg[0];

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_reg     <= 1'b0;
         w_held_reg      <= 1'b0;
         awaddr_reg      <= '0;
         wdata_reg       <= 32'h0000_0000;
         wstrb_reg       <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= DMS_RESP_OKAY;
      end else begin
         aw_held_reg     <= aw_held_next;
         w_held_reg      <= w_held_next;
         awaddr_reg      <= aw_hs ? s_axi_awaddr_i : awaddr_reg;
         wdata_reg       <= w_hs ? s_axi_wdata_i : wdata_reg;
         wstrb_reg       <= w_hs ? s_axi_wstrb_i : wstrb_reg;
         s_axi_awready_o <= ~aw_held_next & ~bvalid_next;
         s_axi_wready_o  <= ~w_held_next & ~bvalid_next;
         s_axi_bvalid_o  <= bvalid_next;
         s_axi_bresp_o   <= wr_fire ? (wr_mapped ? DMS_RESP_OKAY : DMS_RESP_SLVERR) : s_axi_bresp_o;
      end
   end

   // Read channel: one read at a time, answered one cycle after the address is taken.
   logic            ar_hs;
   logic            rvalid_next;
   logic [7:0]      rd_idx;
   logic            rd_high_ok;
   logic            rd_mon;
   logic            rd_irq_st;
   logic            rd_irq_mask;
   logic [3:0]      mon_sel;
   logic [31:0]     rd_word;
   assign ar_hs       = s_axi_arvalid_i & s_axi_arready_o;
   assign rvalid_next = ar_hs | (s_axi_rvalid_o & ~s_axi_rready_i);
   assign rd_idx      = dms_index(s_axi_araddr_i);
   assign rd_high_ok  = dms_high_clear(s_axi_araddr_i);
   assign rd_mon      = rd_high_ok & (rd_idx >= `DMS_IDX_STATUS) & (rd_idx <= `DMS_IDX_HWFAULT2);
   assign rd_irq_st   = rd_high_ok & (rd_idx == `DMS_IDX_IRQ_STATUS);
   assign rd_irq_mask = rd_high_ok & (rd_idx == `DMS_IDX_IRQ_MASK);
   assign mon_sel     = 4'(rd_idx - `DMS_IDX_STATUS);

   // Interrupt status and mask; the status clears on its own read.
   logic [`DMS_IRQ_BITS-1:0] irq_status_reg;
   logic [`DMS_IRQ_BITS-1:0] irq_mask_reg;
   logic [`DMS_IRQ_BITS-1:0] irq_status_next;
   logic [`DMS_IRQ_BITS-1:0] irq_clear;
   assign irq_clear       = (ar_hs & rd_irq_st) ? irq_status_reg : '0;
   // A new event in the clearing cycle survives, so no fault edge is lost to a racing read.
   assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_set;

   // Upper half of the bus word is always zero; monitor words are 16 bits.
   assign rd_word = rd_mon      ? {16'h0000, mon_words[mon_sel]} :
                    rd_irq_st   ? {26'h0000000, irq_status_reg} :
                    rd_irq_mask ? {26'h0000000, irq_mask_reg} : 32'h0000_0000;

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= DMS_RESP_OKAY;
      end else begin
         s_axi_arready_o <= ~rvalid_next;
         s_axi_rvalid_o  <= rvalid_next;
         s_axi_rdata_o   <= ar_hs ? rd_word : s_axi_rdata_o;
         s_axi_rresp_o   <= ar_hs ? ((rd_mon | rd_irq_st | rd_irq_mask) ? DMS_RESP_OKAY : DMS_RESP_SLVERR)
                                  : s_axi_rresp_o;
      end
   end

   // Interrupt registers and output; the output is a flop so it never glitches on the pin.
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_reg <= `DMS_IRQ_STATUS_RST;
         irq_mask_reg   <= `DMS_IRQ_MASK_RST;
         irq_o          <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         irq_mask_reg   <= wr_mask_hit ? wdata_reg[`DMS_IRQ_BITS-1:0] : irq_mask_reg;
         irq_o          <= |(irq_status_next & irq_mask_reg);
      end
   end

   // Checks on the answers that the bank gives.
   default clocking dms_cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   a_ro_write_ignored: assert property (
      wr_fire && wr_idx != `DMS_IDX_IRQ_MASK |=> $stable(irq_mask_reg) && s_axi_bvalid_o)
      else $error("write outside the mask register changed the mask");

   a_panel_type_read: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_OPERATOR
      |=> s_axi_rdata_o[`DMS_OPER_PANEL_MSB:`DMS_OPER_PANEL_LSB] == $past(panel_type_i))
      else $error("panel type field wrong on read");

   a_oper_flags_read: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_OPERATOR
      |=> s_axi_rdata_o[2:0] == $past({prog_mode_i, fault_active_i, parameter_setting_error_i})
          && s_axi_rdata_o[31:5] == '0)
      else $error("operator flags wrong on read");

   a_err_num_read: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_ERR_NUM
      |=> s_axi_rdata_o == {16'h0000, $past(setting_error_num_i)})
      else $error("setting error number wrong on read");

   a_fault_first_read: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_FAULT1
      |=> s_axi_rdata_o[3:0] == $past({undervoltage_fault_i, dc_link_fuse_blown_i}) && !s_axi_rdata_o[4]
          && s_axi_rdata_o[7:5] == $past({dc_link_high_voltage_i, overcurrent_fault_i, earth_leak_fault_i})
          && s_axi_rdata_o[11:8] == $past({drive_overload_i, motor_overload_i, heatsink_hot_trip_i,
                                          heatsink_hot_prewarn_i})
          && s_axi_rdata_o[15:12] == $past({brake_resistor_hot_i, brake_transistor_fault_i,
                                           overtorque_detect_i}))
      else $error("first fault word wrong on read");

   a_fault_second_read: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_FAULT2
      |=> s_axi_rdata_o[6:0] == $past({1'b0, ext_fault_thermistor_input_i, ext_fault_input_i})
          && s_axi_rdata_o[11:7] == $past({output_phase_open_i, input_phase_loss_i, encoder_disconnect_i,
                                           speed_mismatch_trip_i, overspeed_trip_i})
          && s_axi_rdata_o[15:12] == $past({motor_hot_trip_i, bit_e_fault_flag_i, keypad_disconnect_i,
                                           motor_hot_prewarn_i}))
      else $error("second fault word wrong on read");

   a_fault_third_read: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_FAULT3
      |=> s_axi_rdata_o[3:0] == $past({2'b00, option_board_link_fault_i, serial_link_fault_i})
          && s_axi_rdata_o[7:4] == $past({pid_feedback_loss_i, option_card_ext_fault_i, zero_servo_fault_i,
                                          control_fault_i})
          && s_axi_rdata_o[15:8] == $past({5'h00, slip_brake_overload_i, undertorque_detect_i}))
      else $error("third fault word wrong on read");

   a_status_word_read: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_STATUS
      |=> s_axi_rdata_o[7:0] == $past(drive_state_i) && s_axi_rdata_o[13:8] == 6'h00
          && s_axi_rdata_o[15:14] == $past({comm_run_source_flag_i, comm_reference_source_flag_i}))
      else $error("drive status word wrong on read");

   a_hw_words_read: assert property (
      ar_hs && rd_high_ok && (rd_idx == `DMS_IDX_HWFAULT1 || rd_idx == `DMS_IDX_HWFAULT2)
      |=> (s_axi_rdata_o == (($past(rd_idx) == `DMS_IDX_HWFAULT1)
           ? {25'h0, $past(hw_fault_low_i[3:2]), 1'b0, $past(hw_fault_low_i[1:0]), 2'b00}
           : {28'h0, $past(hw_fault_high_i)})))
      else $error("hardware fault word wrong on read");

   a_unused_word_zero: assert property (
      ar_hs && rd_high_ok && rd_idx == `DMS_IDX_UNUSED |=> s_axi_rvalid_o && s_axi_rdata_o == '0)
      else $error("unused word did not read zero");

endmodule : dms_monitor_regs

// ===== hdl/dms_pkg.sv
// Types shared by the drive monitor register bank.
package dms_pkg;

   // One monitor register word.
   typedef logic [15:0] dms_word_t;

   // Bus response codes.
   typedef enum logic [1:0] {
      DMS_RESP_OKAY   = 2'b00,
      DMS_RESP_SLVERR = 2'b10
   } dms_resp_t;

endpackage : dms_pkg

// ===== tb/dms_host.sv
// Host controller model that runs AXI4-Lite register cycles, one at a time.
`timescale 1ns/100ps
module dms_host (
   // Clock.
   input  wire logic        clk_i,
   // Write channels.
   output logic [11:0]      aw_o,
   output logic             awv_o,
   input  wire logic        awr_i,
   output logic [31:0]      wd_o,
   output logic             wv_o,
   input  wire logic        wr_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        bv_i,
   output logic             br_o,
   // Read channels.
   output logic [11:0]      ar_o,
   output logic             arv_o,
   input  wire logic        arr_i,
   input  wire logic [31:0] rd_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic        rv_i,
   output logic             rrdy_o
);
   // The bus is quiet at time zero.
   initial begin
      {aw_o, awv_o, wd_o, wv_o, br_o, ar_o, arv_o, rrdy_o} = '0;
   end

   // Address and data go out together; each drops once taken, so the slave may take them in either order.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      {aw_o, wd_o, awv_o, wv_o, br_o} <= {a, d, 3'b111};
      do begin
         @(posedge clk_i);
         if (awr_i) awv_o <= 1'b0;
         if (wr_i) wv_o <= 1'b0;
      end while (!bv_i);
      r = bresp_i;
      br_o <= 1'b0;
   endtask : wr

   // A read waits for the answer with no cycle limit; only the bench watchdog ends a hang.
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      {ar_o, arv_o, rrdy_o} <= {a, 2'b11};
      do begin
         @(posedge clk_i);
         if (arr_i) arv_o <= 1'b0;
      end while (!rv_i);
      d = rd_i;
      r = rresp_i;
      rrdy_o <= 1'b0;
   endtask : rd
endmodule : dms_host

// ===== tb/dms_monitor_regs_bench.sv
// Self-checking bench of the drive monitor register bank.
`timescale 1ns/100ps
`include "dms_consts.svh"
module dms_monitor_regs_bench;
   import dms_pkg::*;
   localparam logic [15:0] MSK [0:8] = '{16'hc0ff, 16'h001f, 16'hffff, 16'h0000, 16'hffef, 16'hffbf, 16'h07f3,
                                        16'h006c, 16'h000f};
   localparam logic [1:0]  PANEL [0:2] = '{2'b00, 2'b01, 2'b11};
   logic        sys_clk, rst_n, irq, awv_o, wv_o, br_o, arv_o, rrdy_o, awr_i, wr_i, bv_i, arr_i, rv_i;
   logic [15:0] v [0:8];
   logic [11:0] aw_o, ar_o;
   logic [31:0] wd_o, rd_i, d;
   logic [31:0] seed = 32'h49;
   logic [1:0]  r;
   dms_resp_t   bresp_i, rresp_i;
   int          n_fail = 0;
   int          checked = 0;

   dms_host host (.clk_i(sys_clk), .aw_o, .awv_o, .awr_i, .wd_o, .wv_o, .wr_i, .bresp_i, .bv_i, .br_o, .ar_o, .arv_o,
                  .arr_i, .rd_i, .rresp_i, .rv_i, .rrdy_o);

   // Each fault source is wired to the bit it must show, so the expected word is the source word masked.
   dms_monitor_regs dms_monitor_regs_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .s_axi_awaddr_i(aw_o),
      .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awv_o), .s_axi_awready_o(awr_i), .s_axi_wdata_i(wd_o),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv_o), .s_axi_wready_o(wr_i), .s_axi_bresp_o(bresp_i),
      .s_axi_bvalid_o(bv_i), .s_axi_bready_i(br_o), .s_axi_araddr_i(ar_o), .s_axi_arprot_i(3'h0),
      .s_axi_arvalid_i(arv_o), .s_axi_arready_o(arr_i), .s_axi_rdata_o(rd_i), .s_axi_rresp_o(rresp_i),
      .s_axi_rvalid_o(rv_i), .s_axi_rready_i(rrdy_o), .drive_state_i(v[0][7:0]),
      .comm_reference_source_flag_i(v[0][14]),
      .comm_run_source_flag_i(v[0][15]), .parameter_setting_error_i(v[1][0]), .fault_active_i(v[1][1]),
      .prog_mode_i(v[1][2]), .panel_type_i(v[1][4:3]), .setting_error_num_i(v[2]), .dc_link_fuse_blown_i(v[4][0]),
      .undervoltage_fault_i(v[4][3:1]), .earth_leak_fault_i(v[4][5]), .overcurrent_fault_i(v[4][6]),
      .dc_link_high_voltage_i(v[4][7]), .heatsink_hot_prewarn_i(v[4][8]), .heatsink_hot_trip_i(v[4][9]),
      .motor_overload_i(v[4][10]), .drive_overload_i(v[4][11]), .overtorque_detect_i(v[4][13:12]),
      .brake_transistor_fault_i(v[4][14]), .brake_resistor_hot_i(v[4][15]), .ext_fault_input_i(v[5][4:0]),
      .ext_fault_thermistor_input_i(v[5][5]), .overspeed_trip_i(v[5][7]), .speed_mismatch_trip_i(v[5][8]),
      .encoder_disconnect_i(v[5][9]), .input_phase_loss_i(v[5][10]), .output_phase_open_i(v[5][11]),
      .motor_hot_prewarn_i(v[5][12]), .keypad_disconnect_i(v[5][13]), .bit_e_fault_flag_i(v[5][14]),
      .motor_hot_trip_i(v[5][15]), .serial_link_fault_i(v[6][0]), .option_board_link_fault_i(v[6][1]),
      .control_fault_i(v[6][4]), .zero_servo_fault_i(v[6][5]), .option_card_ext_fault_i(v[6][6]),
      .pid_feedback_loss_i(v[6][7]), .undertorque_detect_i(v[6][9:8]), .slip_brake_overload_i(v[6][10]),
      .hw_fault_low_i({v[7][6:5], v[7][3:2]}), .hw_fault_high_i(v[8][3:0]), .irq_o(irq));

   // Clock at 25 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Xorshift source with a fixed start, so every run repeats.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Byte address of a word index and the word expected there.
   function automatic logic [11:0] adr(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction : adr
   function automatic logic [33:0] exp_word(input int i);
      return {DMS_RESP_OKAY, 16'h0000, v[i] & MSK[i]};
   endfunction : exp_word

   // Response code and data are compared together so a wrong code cannot hide.
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // The one place where the run ends.
   task automatic print_verdict();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // The sequence needs about 400 cycles; 20000 cycles leaves ample margin before a hang is called.
   initial begin
      #800000;
      n_fail++;
      print_verdict();
   end

   // Main sequence: random monitor words with panel codes 00, 01 and 11, ignored writes, unmapped places, interrupt.
   initial begin
      rst_n = 1'b0;
      foreach (v[i]) v[i] = 16'h0000;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int n = 0; n < 9; n++) begin
         for (int i = 0; i < 9; i++) v[i] <= (i == 1) ? {11'(rnd()), PANEL[n % 3], 3'(rnd())} : 16'(rnd());
         for (int i = 0; i < 9; i++) begin
            if (n[0]) host.wr(adr(8'h10 + 8'(i)), rnd(), r);
            if (n[0]) chk({r, 32'h0}, {DMS_RESP_OKAY, 32'h0});
            host.rd(adr(8'h10 + 8'(i)), d, r);
            chk({r, d}, exp_word(i));
         end
      end
      host.rd(adr(8'h1f), d, r);
      chk({r, d}, {DMS_RESP_SLVERR, 32'h0});
      host.wr(12'h440, 32'hffff, r);
      chk({r, 32'h0}, {DMS_RESP_SLVERR, 32'h0});
      foreach (v[i]) v[i] <= 16'h0000;
      host.wr(adr(`DMS_IDX_IRQ_MASK), 32'h1, r);
      host.rd(adr(`DMS_IDX_IRQ_MASK), d, r);
      chk({r, d}, {DMS_RESP_OKAY, 32'h1});
      host.rd(adr(`DMS_IDX_IRQ_STATUS), d, r);
      v[5] <= 16'h0002;
      repeat (3) @(posedge sys_clk);
      #1 chk({33'h0, irq}, 34'h0);
      @(posedge sys_clk);
      v[4] <= 16'h0001;
      repeat (3) @(posedge sys_clk);
      #1 chk({33'h0, irq}, 34'h1);
      host.rd(adr(`DMS_IDX_IRQ_STATUS), d, r);
      chk({r, d}, {DMS_RESP_OKAY, 32'h3});
      repeat (2) @(posedge sys_clk);
      #1 chk({33'h0, irq}, 34'h0);
      // A new setting alarm and a second hardware word event land in their own status bits.
      @(posedge sys_clk);
      v[1] <= 16'h0001;
      v[8] <= 16'h0001;
      host.rd(adr(`DMS_IDX_IRQ_STATUS), d, r);
      chk({r, d}, {DMS_RESP_OKAY, 32'h30});
      print_verdict();
   end
endmodule : dms_monitor_regs_bench
